/* erss_pkg.sv */
package erss_pkg;

  // Operation codes issued by the sequencer.
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_ROTATE_RIGHT_CARRY_MEM = 3'b001,
    OP_ROTATE_RIGHT_CARRY_TO_ACC = 3'b010,
    OP_SUBTRACT_BORROW_TO_ACC = 3'b011,
    OP_SUBTRACT_BORROW_TO_MEM = 3'b100,
    OP_DECREMENT_SKIP_IF_ZERO = 3'b101
  } erss_op_t;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic auxiliary_carry_flag;
    logic carry_flag;
    logic signed_compare_flag;
    logic carry_zero_flag;
  } erss_flags_t;

  typedef struct packed {
    logic acc_we;
    logic mem_we;
    logic flags_we;
    logic skip;
    logic [7:0] acc;
    logic [7:0] mem;
    erss_flags_t flags;
  } erss_res_t;

  typedef struct packed {
    logic [15:0] zero_hi;
    logic [7:0] skip_cnt;
    logic busy;
    logic enabled;
    erss_flags_t flags;
  } erss_status_t;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned MSB = 7;
  localparam int unsigned NIB_W = 4;
  localparam logic [7:0] DEC_STEP = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : erss_pkg

/* erss_alu.sv */
`timescale 1ns/10ps
module erss_alu (
  input wire erss_pkg::erss_op_t op, // Operation code
  input wire logic [7:0] mem_in, // Data memory operand
  input wire logic [7:0] acc_in, // Accumulator
  input wire erss_pkg::erss_flags_t flags_in, // Current status flags
  output erss_pkg::erss_res_t res // Result and write enables
);
  logic borrow_w;
  logic [8:0] diff_w;
  logic [4:0] nib_w;
  logic [7:0] dec_w;
  logic [7:0] rrc_w;
  logic sub_ov_w;
  logic sub_z_w;
  erss_pkg::erss_flags_t sub_flags_w;
  erss_pkg::erss_flags_t rrc_flags_w;

  assign borrow_w = ~flags_in.carry_flag;
  assign diff_w = {1'b0, acc_in} - {1'b0, mem_in} - {8'h00, borrow_w};
  assign nib_w = {1'b0, acc_in[3:0]} - {1'b0, mem_in[3:0]} - {4'h0, borrow_w};
  assign dec_w = mem_in - erss_pkg::DEC_STEP;
  assign rrc_w = {flags_in.carry_flag, mem_in[erss_pkg::MSB:1]};
  assign sub_ov_w = (acc_in[erss_pkg::MSB] != mem_in[erss_pkg::MSB])
                    && (diff_w[erss_pkg::MSB] != acc_in[erss_pkg::MSB]);
  assign sub_z_w = (diff_w[erss_pkg::MSB:0] == erss_pkg::ZERO_BYTE);

  // A chained borrow keeps the multi-byte zero state in the carry-zero flag.
  always_comb begin
    sub_flags_w.overflow_flag = sub_ov_w;
    sub_flags_w.zero_flag = sub_z_w;
    sub_flags_w.auxiliary_carry_flag = ~nib_w[erss_pkg::NIB_W];
    sub_flags_w.carry_flag = ~diff_w[erss_pkg::DATA_W];
    sub_flags_w.signed_compare_flag = sub_ov_w ^ diff_w[erss_pkg::MSB];
    sub_flags_w.carry_zero_flag = sub_z_w & flags_in.carry_zero_flag;
    rrc_flags_w = flags_in;
    rrc_flags_w.carry_flag = mem_in[0];
  end

  always_comb begin
    res = '0;
    res.flags = flags_in;
    unique case (op)
      erss_pkg::OP_NOP: begin
        res.flags = flags_in;
      end
      erss_pkg::OP_ROTATE_RIGHT_CARRY_MEM: begin
        res.mem_we = 1'b1;
        res.mem = rrc_w;
        res.flags_we = 1'b1;
        res.flags = rrc_flags_w;
      end
      erss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
        res.acc_we = 1'b1;
        res.acc = rrc_w;
        res.flags_we = 1'b1;
        res.flags = rrc_flags_w;
      end
      erss_pkg::OP_SUBTRACT_BORROW_TO_ACC: begin
        res.acc_we = 1'b1;
        res.acc = diff_w[erss_pkg::MSB:0];
        res.flags_we = 1'b1;
        res.flags = sub_flags_w;
      end
      erss_pkg::OP_SUBTRACT_BORROW_TO_MEM: begin
        res.mem_we = 1'b1;
        res.mem = diff_w[erss_pkg::MSB:0];
        res.flags_we = 1'b1;
        res.flags = sub_flags_w;
      end
      erss_pkg::OP_DECREMENT_SKIP_IF_ZERO: begin
        res.mem_we = 1'b1;
        res.mem = dec_w;
        res.skip = (dec_w == erss_pkg::ZERO_BYTE);
      end
      default: begin
        res.flags = flags_in;
      end
    endcase
  end
endmodule : erss_alu

/* erss_apb.sv */
`timescale 1ns/10ps
module erss_apb (
  input wire logic clk, // Core clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire erss_pkg::erss_status_t status, // Block state for readback
  output logic enable // Execution enable from control register
);
  logic access_w;
  logic hit_ctrl_w;
  logic hit_status_w;
  logic [31:0] rdata_w;
  logic [31:0] ctrl_w;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic en_q;

  // One wait state: ready rises in the second access cycle, so all answers come from flops.
  assign access_w = psel && penable && !pready_q;
  assign hit_ctrl_w = (paddr == erss_pkg::OFF_CTRL);
  assign hit_status_w = (paddr == erss_pkg::OFF_STATUS);
  assign ctrl_w = {31'h0000_0000, en_q};
  assign rdata_w = hit_ctrl_w ? ctrl_w : (hit_status_w ? status : erss_pkg::RDATA_ZERO);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= erss_pkg::RDATA_ZERO;
    end else begin
      pready_q <= access_w;
      pslverr_q <= access_w && !hit_ctrl_w && !hit_status_w;
      prdata_q <= (access_w && !pwrite) ? rdata_w : erss_pkg::RDATA_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= erss_pkg::CTRL_RST[erss_pkg::CTRL_EN_BIT];
    end else if (access_w && pwrite && hit_ctrl_w) begin
      en_q <= pwdata[erss_pkg::CTRL_EN_BIT];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign enable = en_q;
endmodule : erss_apb

/* erss_exec.sv */
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module erss_exec (
  input wire logic clk, // Core instruction clock
  input wire logic rstn, // Core reset, asynchronous, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic ex_req, // Sequencer issues an operation
  input wire erss_pkg::erss_op_t ex_op, // Operation code
  input wire logic [7:0] ex_mem_data, // Data memory operand
  input wire logic [7:0] ex_acc, // Accumulator value
  input wire erss_pkg::erss_flags_t ex_flags, // Current status flags
  output logic ex_done, // Operation finished, one-cycle pulse
  output logic ex_busy, // Dummy cycle pending, requests not taken
  output logic ex_skip, // Pulse with ex_done in the cycle after the dummy cycle: sequencer drops the fetched instruction
  output logic acc_we, // Accumulator write strobe
  output logic [7:0] acc_wdata, // Accumulator write value
  output logic mem_we, // Data memory write strobe
  output logic [7:0] mem_wdata, // Data memory write value
  output logic flags_we, // Status flag write strobe
  output erss_pkg::erss_flags_t flags_wdata // Status flag write value
);
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SKIP = 1'b1
  } erss_state_t;

  erss_state_t state_q;
  logic en_w;
  logic take_w;
  erss_pkg::erss_res_t alu_w;
  erss_pkg::erss_status_t status_w;
  logic done_q;
  logic busy_q;
  logic skip_q;
  logic acc_we_q;
  logic mem_we_q;
  logic flags_we_q;
  logic [7:0] acc_q;
  logic [7:0] mem_q;
  erss_pkg::erss_flags_t flags_q;
  logic [7:0] skip_cnt_q;

  erss_alu u_alu (
    .op(ex_op),
    .mem_in(ex_mem_data),
    .acc_in(ex_acc),
    .flags_in(ex_flags),
    .res(alu_w)
  );

  assign status_w = '{zero_hi: 16'h0000, skip_cnt: skip_cnt_q, busy: busy_q,
                      enabled: en_w, flags: flags_q};

  erss_apb u_apb (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status(status_w),
    .enable(en_w)
  );

  // Requests during the dummy cycle or while disabled are dropped, not queued.
  assign take_w = ex_req && en_w && (state_q == ST_IDLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          skip_q <= 1'b0;
          busy_q <= take_w && alu_w.skip;
          done_q <= take_w && !alu_w.skip;
          state_q <= (take_w && alu_w.skip) ? ST_SKIP : ST_IDLE;
        end
        ST_SKIP: begin
          skip_q <= 1'b1;
          done_q <= 1'b1;
          busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_we_q <= 1'b0;
      mem_we_q <= 1'b0;
      flags_we_q <= 1'b0;
    end else begin
      acc_we_q <= take_w && alu_w.acc_we;
      mem_we_q <= take_w && alu_w.mem_we;
      flags_we_q <= take_w && alu_w.flags_we;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= erss_pkg::ZERO_BYTE;
      mem_q <= erss_pkg::ZERO_BYTE;
      flags_q <= '0;
    end else if (take_w) begin
      acc_q <= alu_w.acc;
      mem_q <= alu_w.mem;
      flags_q <= alu_w.flags;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      skip_cnt_q <= erss_pkg::ZERO_BYTE;
    end else if (state_q == ST_SKIP) begin
      skip_cnt_q <= skip_cnt_q + erss_pkg::DEC_STEP;
    end
  end

  assign ex_done = done_q;
  assign ex_busy = busy_q;
  assign ex_skip = skip_q;
  assign acc_we = acc_we_q;
  assign acc_wdata = acc_q;
  assign mem_we = mem_we_q;
  assign mem_wdata = mem_q;
  assign flags_we = flags_we_q;
  assign flags_wdata = flags_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [8:0] chk_diff_w;
  assign chk_diff_w = {1'b0, ex_acc} - {1'b0, ex_mem_data} - {8'h00, !ex_flags.carry_flag};

  // The true signed difference always fits in nine bits, so an eight-bit signed overflow
  // shows as bits 8 and 7 of this copy differing, and bit 9 is the true sign.
  logic [9:0] chk_sdiff_w;
  assign chk_sdiff_w = {{2{ex_acc[7]}}, ex_acc} - {{2{ex_mem_data[7]}}, ex_mem_data}
                       - {9'h000, !ex_flags.carry_flag};

  sequence s_dsz_zero;
    take_w && ex_op == erss_pkg::OP_DECREMENT_SKIP_IF_ZERO && ex_mem_data == erss_pkg::DEC_STEP;
  endsequence

  sequence s_skip_tail;
    mem_we && mem_wdata == erss_pkg::ZERO_BYTE && !ex_done && ex_busy && !ex_skip
      ##1 ex_skip && ex_done && !mem_we
      ##1 !ex_skip && (!ex_done || $past(take_w));
  endsequence

  sequence s_sbc_take;
    take_w && (ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_ACC
               || ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_MEM);
  endsequence

  sequence s_rrc_take;
    take_w && (ex_op == erss_pkg::OP_ROTATE_RIGHT_CARRY_MEM
               || ex_op == erss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC);
  endsequence

  property p_rrc_mem;
    take_w && ex_op == erss_pkg::OP_ROTATE_RIGHT_CARRY_MEM |=>
      mem_we && !acc_we && mem_wdata == {$past(ex_flags.carry_flag), $past(ex_mem_data[7:1])}
      && flags_wdata.carry_flag == $past(ex_mem_data[0]);
  endproperty
  a_rrc_mem: assert property (p_rrc_mem) else $error("rotate to memory wrong");

  property p_rrc_acc;
    take_w && ex_op == erss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC |=>
      acc_we && acc_wdata[7] == $past(ex_flags.carry_flag)
      && acc_wdata[6:0] == $past(ex_mem_data[7:1])
      && flags_we && flags_wdata.carry_flag == $past(ex_mem_data[0]);
  endproperty
  a_rrc_acc: assert property (p_rrc_acc) else $error("rotate to accumulator wrong");

  property p_rrc_acc_keep_mem;
    take_w && ex_op == erss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC |=> !mem_we;
  endproperty
  a_rrc_acc_keep_mem: assert property (p_rrc_acc_keep_mem) else $error("memory written");

  property p_sbc_acc;
    take_w && ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_ACC |=>
      acc_we && !mem_we && acc_wdata == $past(chk_diff_w[7:0]);
  endproperty
  a_sbc_acc: assert property (p_sbc_acc) else $error("subtract to accumulator wrong");

  property p_sbc_mem;
    take_w && ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_MEM |=>
      mem_we && !acc_we && mem_wdata == $past(chk_diff_w[7:0]);
  endproperty
  a_sbc_mem: assert property (p_sbc_mem) else $error("subtract to memory wrong");

  property p_sbc_carry;
    take_w && (ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_ACC
               || ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_MEM) |=>
      // Nine bits, so an all-ones operand plus the borrow cannot wrap to zero.
      flags_wdata.carry_flag == ({1'b0, $past(ex_acc)} >= {1'b0, $past(ex_mem_data)}
                                 + {8'h00, !$past(ex_flags.carry_flag)});
  endproperty
  a_sbc_carry: assert property (p_sbc_carry) else $error("borrow carry wrong");

  property p_sbc_flags;
    take_w && ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_ACC |=>
      flags_we && flags_wdata.zero_flag == (acc_wdata == erss_pkg::ZERO_BYTE)
      && flags_wdata.signed_compare_flag == (flags_wdata.overflow_flag ^ acc_wdata[7]);
  endproperty
  a_sbc_flags: assert property (p_sbc_flags) else $error("subtract flags wrong");

  property p_dsz_skip;
    s_dsz_zero |=> s_skip_tail;
  endproperty
  a_dsz_skip: assert property (p_dsz_skip) else $error("skip sequence wrong");

  property p_dsz_noskip;
    take_w && ex_op == erss_pkg::OP_DECREMENT_SKIP_IF_ZERO
      && ex_mem_data != erss_pkg::DEC_STEP |=> ex_done && !ex_busy ##1 !ex_skip;
  endproperty
  a_dsz_noskip: assert property (p_dsz_noskip) else $error("unexpected skip");

  property p_dsz_write;
    take_w && ex_op == erss_pkg::OP_DECREMENT_SKIP_IF_ZERO |=>
      mem_we && !flags_we && !acc_we
      && mem_wdata == $past(ex_mem_data) - erss_pkg::DEC_STEP;
  endproperty
  a_dsz_write: assert property (p_dsz_write) else $error("decrement write wrong");

  property p_skip_only_after_dsz;
    $rose(ex_skip) |-> $past(ex_busy) && $past(mem_wdata, 1) == erss_pkg::ZERO_BYTE;
  endproperty
  a_skip_only_after_dsz: assert property (p_skip_only_after_dsz) else $error("stray skip");

  property p_sbc_mem_flags;
    take_w && ex_op == erss_pkg::OP_SUBTRACT_BORROW_TO_MEM |=>
      flags_we && flags_wdata.zero_flag == (mem_wdata == erss_pkg::ZERO_BYTE)
      && flags_wdata.signed_compare_flag == (flags_wdata.overflow_flag ^ mem_wdata[7]);
  endproperty
  a_sbc_mem_flags: assert property (p_sbc_mem_flags) else $error("sbc mem flags");

  property p_sbc_overflow;
    s_sbc_take |=>
      flags_wdata.overflow_flag == ($past(chk_sdiff_w[8]) != $past(chk_sdiff_w[7]));
  endproperty
  a_sbc_overflow: assert property (p_sbc_overflow) else $error("overflow flag wrong");

  property p_sbc_sign;
    s_sbc_take |=> flags_wdata.signed_compare_flag == $past(chk_sdiff_w[9]);
  endproperty
  a_sbc_sign: assert property (p_sbc_sign) else $error("signed compare flag wrong");

  // Five bits, so a low nibble of all ones plus the borrow cannot wrap.
  property p_sbc_aux;
    s_sbc_take |=>
      flags_wdata.auxiliary_carry_flag == ({1'b0, $past(ex_acc[3:0])}
                                           >= {1'b0, $past(ex_mem_data[3:0])}
                                           + {4'h0, !$past(ex_flags.carry_flag)});
  endproperty
  a_sbc_aux: assert property (p_sbc_aux) else $error("aux carry flag wrong");

  property p_sbc_cz;
    s_sbc_take |=> flags_wdata.carry_zero_flag
      == (flags_wdata.zero_flag && $past(ex_flags.carry_zero_flag));
  endproperty
  a_sbc_cz: assert property (p_sbc_cz) else $error("carry zero flag wrong");

  property p_rrc_keep_flags;
    s_rrc_take |=> flags_we
      && flags_wdata.overflow_flag == $past(ex_flags.overflow_flag)
      && flags_wdata.zero_flag == $past(ex_flags.zero_flag)
      && flags_wdata.auxiliary_carry_flag == $past(ex_flags.auxiliary_carry_flag)
      && flags_wdata.signed_compare_flag == $past(ex_flags.signed_compare_flag)
      && flags_wdata.carry_zero_flag == $past(ex_flags.carry_zero_flag);
  endproperty
  a_rrc_keep_flags: assert property (p_rrc_keep_flags) else $error("rotate flags");

  property p_dsz_keep_flags;
    take_w && ex_op == erss_pkg::OP_DECREMENT_SKIP_IF_ZERO |=>
      flags_wdata == $past(ex_flags);
  endproperty
  a_dsz_keep_flags: assert property (p_dsz_keep_flags) else $error("decrement flags");

  // A request held into the dummy cycle must not reach any write strobe.
  property p_busy_drop;
    ex_busy |=> !acc_we && !mem_we && !flags_we;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("write in dummy cycle");

  property p_skip_one;
    ex_skip |=> !ex_skip;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip too long");
endmodule : erss_exec

/* erss_seq_model.sv */
`timescale 1ns/10ps
// Holds one data memory byte, the accumulator and the flags, and takes the block's writes.
module erss_seq_model (
  input wire logic clk, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic ld, // Preload strobe from the bench
  input wire logic [7:0] ld_mem, // Preload memory value
  input wire logic [7:0] ld_acc, // Preload accumulator value
  input wire logic [5:0] ld_flags, // Preload flags
  input wire logic acc_we, // Accumulator write strobe
  input wire logic [7:0] acc_wdata, // Accumulator write value
  input wire logic mem_we, // Memory write strobe
  input wire logic [7:0] mem_wdata, // Memory write value
  input wire logic flags_we, // Flag write strobe
  input wire erss_pkg::erss_flags_t flags_wdata, // Flag write value
  output logic [7:0] mem_q, // Operand byte
  output logic [7:0] acc_q, // Accumulator
  output erss_pkg::erss_flags_t flags_q // Flags
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_q <= 8'h00;
      acc_q <= 8'h00;
      flags_q <= 6'h00;
    end else if (ld) begin
      mem_q <= ld_mem;
      acc_q <= ld_acc;
      flags_q <= ld_flags;
    end else begin
      if (mem_we) mem_q <= mem_wdata;
      if (acc_we) acc_q <= acc_wdata;
      if (flags_we) flags_q <= flags_wdata;
    end
  end
endmodule : erss_seq_model

/* extended_rotate_subtract_skip_exec_test.sv */
`timescale 1ns/10ps
module extended_rotate_subtract_skip_exec_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, ld = 1'b0, ex_req = 1'b0;
  erss_pkg::erss_op_t ex_op = erss_pkg::OP_NOP;
  logic [7:0] ld_mem = 8'h00, ld_acc = 8'h00, mem_q, acc_q, acc_wdata, mem_wdata;
  logic [5:0] ld_flags = 6'h00;
  erss_pkg::erss_flags_t flags_q, flags_wdata;
  logic ex_done, ex_busy, ex_skip, acc_we, mem_we, flags_we;
  logic s_skip, s_busy, s_fwe;
  int n_mismatch = 0, total_checks = 0, n_cyc;

  always #5 clk = ~clk;

  erss_exec i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ex_req(ex_req), .ex_op(ex_op), .ex_mem_data(mem_q), .ex_acc(acc_q), .ex_flags(flags_q),
    .ex_done(ex_done), .ex_busy(ex_busy), .ex_skip(ex_skip), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .mem_we(mem_we), .mem_wdata(mem_wdata), .flags_we(flags_we),
    .flags_wdata(flags_wdata));

  erss_seq_model i_model (.clk(clk), .rstn(rstn), .ld(ld), .ld_mem(ld_mem), .ld_acc(ld_acc),
    .ld_flags(ld_flags), .acc_we(acc_we), .acc_wdata(acc_wdata), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .flags_we(flags_we), .flags_wdata(flags_wdata), .mem_q(mem_q),
    .acc_q(acc_q), .flags_q(flags_q));

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The master holds every signal until pready is sampled high, as the bus requires.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i <= 10; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (i == 10) begin
        n_mismatch++;
        final_report();
      end
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never drives psel twice in one time step.
    @(posedge clk);
  endtask : apb

  task automatic load(input logic [7:0] m, input logic [7:0] a, input logic [5:0] f);
    ld <= 1'b1;
    ld_mem <= m;
    ld_acc <= a;
    ld_flags <= f;
    @(posedge clk);
    ld <= 1'b0;
  endtask : load

  // Holding the request past the take edge checks that a busy cycle drops it.
  task automatic run(input erss_pkg::erss_op_t op, input int hold);
    ex_req <= 1'b1;
    ex_op <= op;
    @(posedge clk);
    {s_skip, s_busy, s_fwe} = 3'h0;
    n_cyc = 0;
    for (int i = 1; i <= 8; i++) begin
      if (i > hold) ex_req <= 1'b0;
      @(posedge clk);
      s_skip |= ex_skip;
      s_busy |= ex_busy;
      s_fwe |= flags_we;
      if (ex_done === 1'b1) begin
        n_cyc = i;
        break;
      end
    end
    @(posedge clk);
  endtask : run

  task automatic sbc(input erss_pkg::erss_op_t op, input logic [7:0] a, input logic [7:0] m,
                     input logic [5:0] f, input logic [7:0] r, input logic [5:0] ef);
    logic to_acc;
    to_acc = (op == erss_pkg::OP_SUBTRACT_BORROW_TO_ACC);
    load(m, a, f);
    run(op, 0);
    chk("sbc cycles", 1, n_cyc);
    chk("sbc result", r, to_acc ? acc_q : mem_q);
    chk("sbc untouched", to_acc ? m : a, to_acc ? mem_q : acc_q);
    chk("sbc flags", ef, flags_q);
    $display("test sbc done");
  endtask : sbc

  task automatic t_regs;
    apb(1'b0, erss_pkg::OFF_CTRL, 32'h0000_0000);
    chk("ctrl reset", erss_pkg::CTRL_RST, rd);
    chk("ctrl err", 0, er);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("unmapped err", 1, er);
    chk("unmapped data", erss_pkg::RDATA_ZERO, rd);
    apb(1'b1, erss_pkg::OFF_CTRL, 32'h0000_0000);
    load(8'h11, 8'h00, 6'h00);
    run(erss_pkg::OP_ROTATE_RIGHT_CARRY_MEM, 0);
    chk("disabled done", 0, n_cyc);
    chk("disabled mem", 8'h11, mem_q);
    apb(1'b1, erss_pkg::OFF_CTRL, erss_pkg::CTRL_RST);
    $display("test regs done");
  endtask : t_regs

  task automatic t_rotate;
    load(8'hA5, 8'h00, 6'h00);
    run(erss_pkg::OP_ROTATE_RIGHT_CARRY_MEM, 0);
    chk("rot mem", 8'h52, mem_q);
    chk("rot mem flags", 6'h04, flags_q);
    load(8'h02, 8'h00, 6'h24);
    run(erss_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC, 0);
    chk("rot acc", 8'h81, acc_q);
    chk("rot acc flags", 6'h20, flags_q);
    chk("rot acc mem", 8'h02, mem_q);
    $display("test rotate done");
  endtask : t_rotate

  task automatic t_dec;
    load(8'h01, 8'h33, 6'h15);
    run(erss_pkg::OP_DECREMENT_SKIP_IF_ZERO, 1);
    chk("dec mem", 8'h00, mem_q);
    chk("dec cycles", 2, n_cyc);
    chk("dec skip", 1, s_skip);
    chk("dec busy", 1, s_busy);
    chk("dec flags we", 0, s_fwe);
    chk("dec flags", 6'h15, flags_q);
    load(8'h00, 8'h33, 6'h2A);
    run(erss_pkg::OP_DECREMENT_SKIP_IF_ZERO, 0);
    chk("dec wrap", 8'hFF, mem_q);
    chk("cont cycles", 1, n_cyc);
    chk("cont skip", 0, s_skip);
    chk("cont flags", 6'h2A, flags_q);
    apb(1'b0, erss_pkg::OFF_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0140, rd & 32'h0000_FF40);
    $display("test dec done");
  endtask : t_dec

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_rotate();
    sbc(erss_pkg::OP_SUBTRACT_BORROW_TO_ACC, 8'h10, 8'h20, 6'h04, 8'hF0, 6'h0A);
    sbc(erss_pkg::OP_SUBTRACT_BORROW_TO_ACC, 8'h80, 8'h01, 6'h00, 8'h7E, 6'h26);
    sbc(erss_pkg::OP_SUBTRACT_BORROW_TO_MEM, 8'h05, 8'h04, 6'h01, 8'h00, 6'h1D);
    t_dec();
    final_report();
  end

  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule : extended_rotate_subtract_skip_exec_test
